// >>> common/agp_pkg.sv
// shared constants and types for the graphics-port request queues
package agp_pkg;
	localparam int ADDR_W = 32;
	localparam int DATA_W = 32;
	localparam int LEN_W = 4;
	localparam int RQ_DEPTH = 16;
	localparam int SQ_DEPTH = 6;
	localparam int MAX_OUTSTANDING = 22;
	localparam int SYNC_STAGES = 3;
	localparam int PAGE_W = 12;
	localparam int APER_IDX_W = 4;
	localparam int APER_PAGES = 16;
	localparam int PFN_W = ADDR_W - PAGE_W;
	localparam logic [ADDR_W-1:0] APER_BASE = 32'he000_0000;
	localparam int MIN_AGP_BYTES = 8;
	localparam int CLK_SYS_MHZ = 50;
	localparam int LINK_CLK_NOM_KHZ = 66600;
	localparam logic [2:0] BEATS_1X = 3'h1;
	localparam logic [2:0] BEATS_2X = 3'h2;
	localparam logic [2:0] BEATS_4X = 3'h4;
	typedef enum logic [1:0] {RATE_1X, RATE_2X, RATE_4X} rate_t;
	typedef struct packed {
		logic write;
		logic high;
		logic [LEN_W-1:0] len;
		logic [ADDR_W-1:0] addr;
	} req_t;
endpackage

// >>> design/svc_fifo.sv
// parameterised fifo used as the service queue
`timescale 1ns/100ps
module svc_fifo #(
	parameter int W = 8,
	parameter int DEPTH = 16,
	parameter int CW = $clog2(DEPTH + 1)
) (
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [W-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [W-1:0] out_data,
	output logic [CW-1:0] count
);
	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	typedef struct packed {
		logic [DEPTH-1:0][W-1:0] mem;
		logic [PW-1:0] wr;
		logic [PW-1:0] rd;
		logic [CW-1:0] cnt;
	} fifo_st_t;
	fifo_st_t st_reg, st_next;
	logic push, pop;

	assign in_ready = (st_reg.cnt != CW'(DEPTH));
	assign out_valid = (st_reg.cnt != '0);
	assign out_data = st_reg.mem[st_reg.rd];
	assign count = st_reg.cnt;
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	always_comb begin
		st_next = st_reg;
		if (push) begin
			st_next.mem[st_reg.wr] = in_data;
			st_next.wr = (st_reg.wr == PW'(DEPTH - 1)) ? '0 : PW'(st_reg.wr + 1'b1);
		end
		if (pop) begin
			st_next.rd = (st_reg.rd == PW'(DEPTH - 1)) ? '0 : PW'(st_reg.rd + 1'b1);
		end
		st_next.cnt = CW'(st_reg.cnt + CW'(push) - CW'(pop));
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	property p_fifo_bound;
		@(posedge clk_sys) disable iff (!resetn) st_reg.cnt <= CW'(DEPTH);
	endproperty
	a_fifo_bound: assert property (p_fifo_bound) else $error("fifo count above depth");
	property p_fifo_full_refuse;
		@(posedge clk_sys) disable iff (!resetn)
			(st_reg.cnt == CW'(DEPTH)) && !out_ready |=> st_reg.cnt == CW'(DEPTH);
	endproperty
	a_fifo_full_refuse: assert property (p_fifo_full_refuse) else $error("fifo full changed");
endmodule // svc_fifo

// >>> design/agp_target_request_queues.sv
// graphics-port target: request queue, service queue and aperture remap
`timescale 1ns/100ps
// Notes on behaviour
// - 32-bit link at 1x, 2x or 4x rates
// - up to 22 transactions outstanding at once
// - target for port requests; pci cycles are only flagged on pci_cycle
// - detected requests stored in 16-entry queue
// - queue orders by priority and ordering rules
// - data-ready requests move to 6-entry service queue
// - one queue: low/high priority by flag, reads and writes kept in arrival order
// - high priority passes low priority automatically
// - frame low means a pci cycle
// - port logic runs on clk_sys; link clock is sampled
// - aperture addresses remapped through relocation table
module agp_target_request_queues
	import agp_pkg::*;
#(
	parameter int RQ_N = agp_pkg::RQ_DEPTH,
	parameter int SQ_N = agp_pkg::SQ_DEPTH,
	parameter int MAX_OUT = agp_pkg::MAX_OUTSTANDING
) (
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic link_clk,
	input wire logic frame_n,
	input wire logic req_valid,
	input wire logic req_sideband,
	input wire logic req_write,
	input wire logic req_high,
	input wire logic [agp_pkg::LEN_W-1:0] req_len,
	input wire logic [agp_pkg::ADDR_W-1:0] req_addr,
	input wire agp_pkg::rate_t rate_sel,
	input wire logic tbl_we,
	input wire logic [agp_pkg::APER_IDX_W-1:0] tbl_idx,
	input wire logic [agp_pkg::PFN_W-1:0] tbl_pfn,
	input wire logic mem_ready,
	input wire logic svc_ready,
	output logic req_ready,
	output logic pci_cycle,
	output logic [2:0] link_beats,
	output logic svc_valid,
	output logic svc_write,
	output logic svc_high,
	output logic [agp_pkg::LEN_W-1:0] svc_len,
	output logic [agp_pkg::ADDR_W-1:0] svc_addr,
	output logic [4:0] outstanding
);
	import agp_pkg::*;
	localparam int CW = $clog2(RQ_N + 1);
	localparam int IW = $clog2(RQ_N);
	localparam int SCW = $clog2(SQ_N + 1);

	typedef struct packed {
		logic [SYNC_STAGES-1:0] lclk_s;
		logic lclk_st;
		logic [SYNC_STAGES-1:0] frame_s;
		logic frame_st;
		req_t [RQ_N-1:0] q;
		logic [CW-1:0] cnt;
		logic [APER_PAGES-1:0][PFN_W-1:0] tbl;
		logic req_ready;
		logic pci_cycle;
		logic [2:0] beats;
		logic svc_valid;
		req_t svc;
		logic [4:0] outstanding;
	} st_t;
	st_t st_reg, st_next;

	logic lk_rise, accept, move, fifo_in_ready, fifo_out_valid, fifo_out_ready;
	logic [RQ_N-1:0] high_vld;
	logic [IW-1:0] sel;
	logic [SCW-1:0] fifo_count;
	logic [4:0] occ;
	req_t sel_req, fifo_in_data, fifo_out_data;

	// ************************************************************
	// helpers
	// ************************************************************
	function automatic logic in_aperture(input logic [ADDR_W-1:0] a);
		in_aperture = (a >= APER_BASE) &&
			(a < APER_BASE + ADDR_W'(APER_PAGES << PAGE_W));
	endfunction

	function automatic req_t remap(input req_t r, input logic [APER_PAGES-1:0][PFN_W-1:0] t);
		logic [ADDR_W-1:0] off;
		remap = r;
		off = r.addr - APER_BASE;
		if (in_aperture(r.addr)) begin
			remap.addr = {t[off[PAGE_W +: APER_IDX_W]], r.addr[PAGE_W-1:0]};
		end
	endfunction

	// ************************************************************
	// link sampling and request selection
	// ************************************************************
	// link clock is slow against clk_sys, so its edges are found by sampling
	assign lk_rise = (st_reg.lclk_s[1] == st_reg.lclk_s[2]) && st_reg.lclk_s[2] && !st_reg.lclk_st;
	assign occ = 5'(st_reg.cnt) + 5'(fifo_count) + 5'(st_reg.svc_valid);
	assign accept = lk_rise && !st_reg.frame_st && req_valid &&
		(st_reg.cnt < CW'(RQ_N)) && (occ < 5'(MAX_OUT));

	// queue holds arrival order; oldest high entry wins, else oldest entry
	always_comb begin
		sel = '0;
		for (int i = RQ_N - 1; i >= 0; i--) begin
			if ((CW'(i) < st_reg.cnt) && st_reg.q[i].high) begin
				sel = IW'(i);
			end
		end
	end
	// occupied high entries, built apart from the selection loop for the check below
	for (genvar g = 0; g < RQ_N; g++) begin : g_high
		assign high_vld[g] = (CW'(g) < st_reg.cnt) && st_reg.q[g].high;
	end
	assign sel_req = st_reg.q[sel];
	assign move = mem_ready && (st_reg.cnt != '0) && fifo_in_ready;
	assign fifo_in_data = remap(sel_req, st_reg.tbl);
	assign fifo_out_ready = !st_reg.svc_valid || svc_ready;

	svc_fifo #(.W($bits(req_t)), .DEPTH(SQ_N)) u_svc_fifo (
		.clk_sys(clk_sys),
		.resetn(resetn),
		.in_valid(move),
		.in_ready(fifo_in_ready),
		.in_data(fifo_in_data),
		.out_valid(fifo_out_valid),
		.out_ready(fifo_out_ready),
		.out_data(fifo_out_data),
		.count(fifo_count)
	);

	// ************************************************************
	// next state
	// ************************************************************
	always_comb begin
		st_next = st_reg;
		st_next.lclk_s = {st_reg.lclk_s[SYNC_STAGES-2:0], link_clk};
		// kept as frame asserted, so the reset value matches the idle pin
		st_next.frame_s = {st_reg.frame_s[SYNC_STAGES-2:0], !frame_n};
		if (st_reg.lclk_s[1] == st_reg.lclk_s[2]) begin
			st_next.lclk_st = st_reg.lclk_s[2];
		end
		if (st_reg.frame_s[1] == st_reg.frame_s[2]) begin
			st_next.frame_st = st_reg.frame_s[2];
		end
		// frame low: the cycle belongs to pci and never enters the queue
		if (lk_rise) begin
			st_next.pci_cycle = st_reg.frame_st;
		end
		if (move) begin
			for (int i = 0; i < RQ_N - 1; i++) begin
				if (i >= int'(sel)) begin
					st_next.q[i] = st_reg.q[i+1];
				end
			end
			st_next.cnt = CW'(st_reg.cnt - 1'b1);
		end
		if (accept) begin
			st_next.q[st_next.cnt].write = req_write;
			st_next.q[st_next.cnt].high = req_high;
			st_next.q[st_next.cnt].len = req_len;
			st_next.q[st_next.cnt].addr = req_addr;
			st_next.cnt = CW'(st_next.cnt + 1'b1);
		end
		if (tbl_we) begin
			st_next.tbl[tbl_idx] = tbl_pfn;
		end
		st_next.req_ready = st_next.cnt < CW'(RQ_N);
		case (rate_sel)
			RATE_2X: st_next.beats = BEATS_2X;
			RATE_4X: st_next.beats = BEATS_4X;
			default: st_next.beats = BEATS_1X;
		endcase
		if (fifo_out_ready) begin
			st_next.svc_valid = fifo_out_valid;
			st_next.svc = fifo_out_data;
		end
		st_next.outstanding = occ;
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign req_ready = st_reg.req_ready;
	assign pci_cycle = st_reg.pci_cycle;
	assign link_beats = st_reg.beats;
	assign svc_valid = st_reg.svc_valid;
	assign svc_write = st_reg.svc.write;
	assign svc_high = st_reg.svc.high;
	assign svc_len = st_reg.svc.len;
	assign svc_addr = st_reg.svc.addr;
	assign outstanding = st_reg.outstanding;

	// ************************************************************
	// checks
	// ************************************************************
	property p_rq_bound;
		@(posedge clk_sys) disable iff (!resetn) st_reg.cnt <= CW'(RQ_N);
	endproperty
	a_rq_bound: assert property (p_rq_bound) else $error("request queue overfilled");
	property p_out_bound;
		@(posedge clk_sys) disable iff (!resetn) occ <= 5'(MAX_OUT);
	endproperty
	a_out_bound: assert property (p_out_bound) else $error("too many outstanding");
	property p_full_refuse;
		@(posedge clk_sys) disable iff (!resetn) (st_reg.cnt == CW'(RQ_N)) |-> !req_ready;
	endproperty
	a_full_refuse: assert property (p_full_refuse) else $error("ready while queue full");
	property p_pci_no_enq;
		@(posedge clk_sys) disable iff (!resetn)
			lk_rise && st_reg.frame_st |=> pci_cycle && (st_reg.cnt <= $past(st_reg.cnt));
	endproperty
	a_pci_no_enq: assert property (p_pci_no_enq) else $error("pci cycle queued");
	property p_enq;
		@(posedge clk_sys) disable iff (!resetn)
			accept && !move |=> st_reg.cnt == CW'($past(st_reg.cnt) + 1'b1);
	endproperty
	a_enq: assert property (p_enq) else $error("request not stored");
	property p_high_first;
		@(posedge clk_sys) disable iff (!resetn) move && (high_vld != '0) |-> sel_req.high;
	endproperty
	a_high_first: assert property (p_high_first) else $error("low passed high");
	sequence s_moved;
		move && (fifo_count == '0) && !st_reg.svc_valid;
	endsequence
	sequence s_delivered;
		##[1:2] svc_valid;
	endsequence
	property p_move_path;
		@(posedge clk_sys) disable iff (!resetn) s_moved |-> s_delivered;
	endproperty
	a_move_path: assert property (p_move_path) else $error("moved request lost");
	property p_remap;
		@(posedge clk_sys) disable iff (!resetn)
			move && in_aperture(sel_req.addr) |->
			fifo_in_data.addr[PAGE_W-1:0] == sel_req.addr[PAGE_W-1:0];
	endproperty
	a_remap: assert property (p_remap) else $error("page offset altered");
	property p_beats;
		@(posedge clk_sys) disable iff (!resetn) rate_sel == RATE_4X |=> link_beats == BEATS_4X;
	endproperty
	a_beats: assert property (p_beats) else $error("wrong beat count");
endmodule // agp_target_request_queues

// >>> dv/agp_initiator_model.sv
// initiator model: drives the link clock, frame and request fields
`timescale 1ns/100ps
module agp_initiator_model
	import agp_pkg::*;
(
	input wire logic clk_sys,
	output logic link_clk,
	output logic frame_n,
	output logic req_valid,
	output logic req_sideband,
	output logic req_write,
	output logic req_high,
	output logic [agp_pkg::LEN_W-1:0] req_len,
	output logic [agp_pkg::ADDR_W-1:0] req_addr
);
	initial begin
		link_clk = 1'b0;
		frame_n = 1'b1;
		req_valid = 1'b0;
		req_sideband = 1'b0;
		req_write = 1'b0;
		req_high = 1'b0;
		req_len = 4'h0;
		req_addr = 32'h0;
	end

	// one link period; clock stands still low between periods
	task automatic send(input logic w, input logic h, input logic [LEN_W-1:0] len,
		input logic [ADDR_W-1:0] a, input logic sb);
		@(posedge clk_sys);
		frame_n <= (len < MIN_AGP_BYTES) ? 1'b0 : 1'b1;
		req_valid <= 1'b1;
		req_sideband <= sb;
		req_write <= w;
		req_high <= h;
		req_len <= len;
		req_addr <= a;
		repeat (4) @(posedge clk_sys);
		link_clk <= 1'b1;
		repeat (4) @(posedge clk_sys);
		link_clk <= 1'b0;
		// fields are read unsynchronised, so hold them past the edge
		repeat (4) @(posedge clk_sys);
		frame_n <= 1'b1;
		req_valid <= 1'b0;
		req_write <= ~w;
		req_high <= ~h;
		req_len <= ~len;
		req_addr <= ~a;
	endtask
endmodule // agp_initiator_model

// >>> dv/tb.sv
// self-checking testbench for the graphics-port request queues
`timescale 1ns/100ps
`define CHK(chk_name, chk_exp, chk_got) begin samples_checked++; \
	if ((chk_got) !== (chk_exp)) begin fail_count++; \
	$display("[ERR] %s exp %0h got %0h", chk_name, chk_exp, chk_got); end end
module tb;
	import agp_pkg::*;
	logic clk_sys, resetn, link_clk, frame_n, req_valid, req_sideband, req_write, req_high;
	logic tbl_we, mem_ready, svc_ready, req_ready, pci_cycle, svc_valid, svc_write, svc_high;
	logic [LEN_W-1:0] req_len, svc_len;
	logic [ADDR_W-1:0] req_addr, svc_addr;
	logic [APER_IDX_W-1:0] tbl_idx;
	logic [PFN_W-1:0] tbl_pfn;
	logic [2:0] link_beats;
	logic [4:0] outstanding;
	rate_t rate_sel;
	int fail_count, samples_checked;
	logic [33:0] got[$];
	logic [LEN_W-1:0] got_len[$];

	agp_initiator_model i_init (.clk_sys, .link_clk, .frame_n, .req_valid, .req_sideband,
		.req_write, .req_high, .req_len, .req_addr);
	agp_target_request_queues i_dut (.clk_sys, .resetn, .link_clk, .frame_n, .req_valid,
		.req_sideband, .req_write, .req_high, .req_len, .req_addr, .rate_sel, .tbl_we,
		.tbl_idx, .tbl_pfn, .mem_ready, .svc_ready, .req_ready, .pci_cycle, .link_beats,
		.svc_valid, .svc_write, .svc_high, .svc_len, .svc_addr, .outstanding);

	initial begin
		clk_sys = 1'b0;
		forever #10 clk_sys = ~clk_sys;
	end

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	initial begin
		repeat (50000) @(posedge clk_sys);
		fail_count++;
		end_of_test();
	end

	// ****
	// scenarios
	// ****
	task automatic drain(input int n);
		int k;
		got.delete();
		got_len.delete();
		mem_ready <= 1'b1;
		svc_ready <= 1'b1;
		for (k = 0; k < 400 && got.size() < n; k++) begin
			@(negedge clk_sys);
			if (svc_valid === 1'b1) begin
				got.push_back({svc_write, svc_high, svc_addr});
				got_len.push_back(svc_len);
			end
			@(posedge clk_sys);
		end
		`CHK("drained", n, got.size())
		repeat (4) @(posedge clk_sys);
		`CHK("idle_valid", 1'b0, svc_valid)
		`CHK("idle_out", 5'h00, outstanding)
		mem_ready <= 1'b0;
	endtask

	task automatic t_rate();
		rate_t r[3] = '{RATE_1X, RATE_2X, RATE_4X};
		logic [2:0] b[3] = '{BEATS_1X, BEATS_2X, BEATS_4X};
		for (int i = 0; i < 3; i++) begin
			rate_sel <= r[i];
			repeat (3) @(posedge clk_sys);
			`CHK("beats", b[i], link_beats)
		end
	endtask

	task automatic t_pci();
		i_init.send(1'b0, 1'b0, 4'h4, 32'h0000_0040, 1'b0);
		`CHK("pci", 1'b1, pci_cycle)
		`CHK("pci_out", 5'h00, outstanding)
		i_init.send(1'b0, 1'b0, 4'h8, 32'h0000_0080, 1'b1);
		`CHK("agp", 1'b0, pci_cycle)
		`CHK("agp_out", 5'h01, outstanding)
		drain(1);
		`CHK("agp_addr", 34'h0_0000_0080, got[0])
		`CHK("agp_len", 4'h8, got_len[0])
	endtask

	// high priority passes low; arrival order inside a priority
	task automatic t_prio();
		logic [33:0] e[4] = '{{2'b11, 32'h200}, {2'b01, 32'h400}, {2'b00, 32'h100},
			{2'b10, 32'h300}};
		i_init.send(1'b0, 1'b0, 4'h8, 32'h100, 1'b0);
		i_init.send(1'b1, 1'b1, 4'h8, 32'h200, 1'b1);
		i_init.send(1'b1, 1'b0, 4'h8, 32'h300, 1'b0);
		i_init.send(1'b0, 1'b1, 4'h8, 32'h400, 1'b1);
		`CHK("held", 5'h04, outstanding)
		drain(4);
		for (int i = 0; i < 4; i++) `CHK("order", e[i], got[i])
	endtask

	task automatic t_remap();
		@(posedge clk_sys);
		tbl_we <= 1'b1;
		tbl_idx <= 4'h3;
		tbl_pfn <= 20'h12345;
		@(posedge clk_sys);
		tbl_we <= 1'b0;
		i_init.send(1'b0, 1'b0, 4'h8, APER_BASE + 32'h3abc, 1'b0);
		i_init.send(1'b0, 1'b0, 4'h8, APER_BASE + 32'h10010, 1'b1);
		drain(2);
		`CHK("remap", 32'h1234_5abc, got[0][31:0])
		`CHK("outside", APER_BASE + 32'h10010, got[1][31:0])
	endtask

	// consumer stalls while requests pile up to the occupancy limit
	task automatic t_limit();
		@(posedge clk_sys);
		mem_ready <= 1'b1;
		svc_ready <= 1'b0;
		for (int i = 0; i < 23; i++) i_init.send(1'b0, 1'b0, 4'h8, 32'h1000 + i * 16, i[0]);
		`CHK("limit", 5'd22, outstanding)
		`CHK("moved", 1'b1, req_ready)
		drain(22);
		for (int i = 0; i < 22; i++) `CHK("fifo", 32'h1000 + i * 16, got[i][31:0])
	endtask

	task automatic t_full();
		for (int i = 0; i < 17; i++) i_init.send(1'b1, 1'b0, 4'h8, 32'h2000 + i * 16, i[0]);
		`CHK("full", 5'd16, outstanding)
		`CHK("refuse", 1'b0, req_ready)
		drain(16);
		`CHK("last", 32'h20f0, got[15][31:0])
		`CHK("reopen", 1'b1, req_ready)
	endtask

	// reset in mid-run empties the queue and the occupancy count
	task automatic t_reset();
		i_init.send(1'b0, 1'b1, 4'h8, 32'h0000_3000, 1'b0);
		i_init.send(1'b1, 1'b0, 4'h8, 32'h0000_3010, 1'b1);
		`CHK("pre_rst", 5'h02, outstanding)
		@(posedge clk_sys);
		resetn <= 1'b0;
		repeat (3) @(posedge clk_sys);
		resetn <= 1'b1;
		repeat (5) @(posedge clk_sys);
		`CHK("rst2_ready", 1'b1, req_ready)
		`CHK("rst2_out", 5'h00, outstanding)
		drain(0);
	endtask

	initial begin
		resetn = 1'b0;
		tbl_we = 1'b0;
		tbl_idx = 4'h0;
		tbl_pfn = 20'h0;
		mem_ready = 1'b0;
		svc_ready = 1'b0;
		rate_sel = RATE_1X;
		repeat (10) @(posedge clk_sys);
		resetn <= 1'b1;
		repeat (5) @(posedge clk_sys);
		`CHK("rst_ready", 1'b1, req_ready)
		`CHK("rst_valid", 1'b0, svc_valid)
		t_rate();
		t_pci();
		t_prio();
		t_remap();
		t_limit();
		t_full();
		t_reset();
		end_of_test();
	end
endmodule // tb
